// ### interrupt_vector_placement.sv
/*
  Interrupt vector placement controller: control register with a timed
  unlock guarding the vector-select bit, automatic interrupt blocking,
  boot lock blocking, and the reset and vector address generation.
  Assumes the CPU core on the same clock writes the register through a
  strobe, marks retired instructions with a pulse and reports whether it
  executes from the boot section. Fuses and lock bits arrive as levels.
  // Overview of operation
  // - With vector select clear the table starts at the beginning of flash.
  // - With vector select set the table moves to the boot section start chosen by the boot size fuses.
  // - Software sets the change unlock first and vector select only changes while it is active.
  // - Hardware drops the unlock four cycles after it was set, or at the select write.
  // - Interrupts stay blocked from the unlock until the instruction after the select write retires.
  // - Without a select write interrupts are blocked for four cycles and then released.
  // - The blocking never touches the global interrupt enable flag of the core.
  // - Vectors in boot with the application side lock set block interrupts while running application code.
  // - Vectors in application with the boot side lock set block interrupts while running boot code.
  // - With a 4K boot section and moved vectors the first external vector is at 3802 up to 3828.
  // - With the boot reset fuse set and a 4K boot section reset starts at 3800 and vectors stay at 002.
  // - Moved vector addresses are the normal table address plus the boot section start.
  // - Boot reset fuse one resets to zero, zero resets to the boot reset address.
*/
`timescale 1ns/100ps

module interrupt_vector_placement
	import vector_placement_pkg::*;
#(
	parameter logic [13:0] BOOT_START_SZ0 = BOOT_START_4K,  // Boot start, size fuses 00
	parameter logic [13:0] BOOT_START_SZ1 = BOOT_START_4K,  // Boot start, size fuses 01
	parameter logic [13:0] BOOT_START_SZ2 = BOOT_START_4K,  // Boot start, size fuses 10
	parameter logic [13:0] BOOT_START_SZ3 = BOOT_START_4K   // Boot start, size fuses 11
) (
	input  wire logic                 i_mclk,          // System clock, 250 MHz
	input  wire logic                 i_reset,         // Synchronous reset, high
	input  wire ctrl_write_s          i_ctrl_write,    // Control register write strobe and data
	input  wire logic                 i_instr_done,    // Pulse: an instruction retired
	input  wire logic                 i_exec_in_boot,  // Level: executing from boot section
	input  wire fuse_cfg_s            i_fuses,         // Fuse and lock levels, asynchronous
	input  wire logic [VEC_NUM_W-1:0] i_vector_num,    // Vector number to look up
	output logic      [CTRL_W-1:0]    o_ctrl_rdata,    // Control register read value
	output logic                      o_irq_block,     // High while interrupts are held off
	output logic      [ADDR_W-1:0]    o_vector_addr,   // Word address of the looked-up vector
	output logic      [ADDR_W-1:0]    o_reset_addr     // Word address execution starts at
);

	fuse_cfg_s                fuse_sync;
	logic                     select_ff;
	logic                     nxt_select;
	logic                     unlock_ff;
	logic                     nxt_unlock;
	logic [UNLOCK_CNT_W-1:0]  unlock_cnt_ff;
	logic [UNLOCK_CNT_W-1:0]  nxt_unlock_cnt;
	logic                     hold_ff;
	logic                     nxt_hold;
	logic                     unlock_write;
	logic                     select_write;
	logic                     lock_block;
	logic                     block_any;
	logic [ADDR_W-1:0]        boot_start;
	logic [ADDR_W-1:0]        table_base;
	logic [ADDR_W-1:0]        vector_offset;
	logic [ADDR_W-1:0]        nxt_vector_addr;
	logic [ADDR_W-1:0]        nxt_reset_addr;

	// Fuses come from outside the clock domain
	level_sync #(
		.WIDTH     (FUSE_CFG_W),
		.RESET_VAL (32'(FUSE_CFG_RESET))
	) u_fuse_sync (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_async (i_fuses),
		.o_sync  (fuse_sync)
	);

	// Decode the two kinds of register write
	always_comb
	begin
		unlock_write = i_ctrl_write.wr && i_ctrl_write.data[CTRL_UNLOCK_BIT];
		select_write = i_ctrl_write.wr && !i_ctrl_write.data[CTRL_UNLOCK_BIT] && unlock_ff;
	end

	// Vector select only moves inside the unlock window
	always_comb
	begin
		nxt_select = select_ff;
		if (select_write)
		begin
			nxt_select = i_ctrl_write.data[CTRL_SELECT_BIT];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			select_ff <= CTRL_RESET_VALUE[CTRL_SELECT_BIT];
		end
		else
		begin
			select_ff <= nxt_select;
		end
	end

	// Unlock window: a fresh unlock re-arms the full four cycles
	always_comb
	begin
		nxt_unlock     = unlock_ff;
		nxt_unlock_cnt = unlock_cnt_ff;
		if (unlock_write)
		begin
			nxt_unlock     = 1'b1;
			nxt_unlock_cnt = UNLOCK_LOAD;
		end
		else if (select_write)
		begin
			nxt_unlock     = 1'b0;
			nxt_unlock_cnt = '0;
		end
		else if (unlock_ff)
		begin
			nxt_unlock_cnt = unlock_cnt_ff - UNLOCK_ONE;
			if (unlock_cnt_ff == UNLOCK_ONE)
			begin
				nxt_unlock = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			unlock_ff     <= CTRL_RESET_VALUE[CTRL_UNLOCK_BIT];
			unlock_cnt_ff <= '0;
		end
		else
		begin
			unlock_ff     <= nxt_unlock;
			unlock_cnt_ff <= nxt_unlock_cnt;
		end
	end

	// Hold after a select write until the next instruction retires
	always_comb
	begin
		nxt_hold = hold_ff;
		if (select_write)
		begin
			nxt_hold = 1'b1;
		end
		else if (hold_ff && i_instr_done)
		begin
			nxt_hold = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			hold_ff <= 1'b0;
		end
		else
		begin
			hold_ff <= nxt_hold;
		end
	end

	// Lock bits forbid vectors living in the other section
	always_comb
	begin
		lock_block = 1'b0;
		if (select_ff && fuse_sync.app_side_boot_lock == FUSE_PROGRAMMED && !i_exec_in_boot)
		begin
			lock_block = 1'b1;
		end
		if (!select_ff && fuse_sync.boot_side_boot_lock == FUSE_PROGRAMMED && i_exec_in_boot)
		begin
			lock_block = 1'b1;
		end
	end

	// Every reason to hold interrupts off, gathered in one place
	always_comb
	begin
		block_any = 1'b0;
		if (nxt_unlock)
		begin
			block_any = 1'b1;
		end
		if (nxt_hold || lock_block)
		begin
			block_any = 1'b1;
		end
	end

	// A separate gate, so the core's global enable flag is never written
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_irq_block <= 1'b0;
		end
		else
		begin
			o_irq_block <= block_any;
		end
	end

	// Boot section start from the size fuses
	always_comb
	begin
		case (fuse_sync.boot_size_fuses)
			2'h0:    boot_start = BOOT_START_SZ0;
			2'h1:    boot_start = BOOT_START_SZ1;
			2'h2:    boot_start = BOOT_START_SZ2;
			2'h3:    boot_start = BOOT_START_SZ3;
			default: boot_start = BOOT_START_SZ0;
		endcase
	end

	// Table base follows the select bit
	always_comb
	begin
		if (select_ff)
		begin
			table_base = boot_start;
		end
		else
		begin
			table_base = FLASH_START;
		end
	end

	// Normal table offset is two words per vector after reset
	always_comb
	begin
		vector_offset = ADDR_W'(i_vector_num - VEC_RESET_NUM) * VECTOR_STRIDE;
	end

	// Reset address from the boot reset fuse
	always_comb
	begin
		if (fuse_sync.boot_reset_fuse == FUSE_PROGRAMMED)
		begin
			nxt_reset_addr = boot_start;
		end
		else
		begin
			nxt_reset_addr = FLASH_START;
		end
	end

	// Reset entry reports the reset address; out of range numbers clamp to the last entry
	always_comb
	begin
		if (i_vector_num == VEC_RESET_NUM)
		begin
			nxt_vector_addr = nxt_reset_addr;
		end
		else if (i_vector_num > VEC_LAST_NUM || i_vector_num == '0)
		begin
			nxt_vector_addr = table_base + ADDR_W'(VEC_LAST_NUM - VEC_RESET_NUM) * VECTOR_STRIDE;
		end
		else
		begin
			nxt_vector_addr = table_base + vector_offset;
		end
	end

	// Address outputs registered, one cycle behind the lookup
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_vector_addr <= FLASH_START;
			o_reset_addr  <= FLASH_START;
		end
		else
		begin
			o_vector_addr <= nxt_vector_addr;
			o_reset_addr  <= nxt_reset_addr;
		end
	end

	// Read value: unused bits held at zero
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_ctrl_rdata <= CTRL_RESET_VALUE;
		end
		else
		begin
			o_ctrl_rdata                  <= '0;
			o_ctrl_rdata[CTRL_SELECT_BIT] <= nxt_select;
			o_ctrl_rdata[CTRL_UNLOCK_BIT] <= nxt_unlock;
		end
	end

endmodule

// ### vector_placement_pkg.sv
/*
  Shared constants and carrier types for the interrupt vector placement
  block: control register layout, reset values, unlock window length and
  the address arithmetic constants of the vector table.
  Assumes a word-addressed program flash of at most 16K words.
*/
package vector_placement_pkg;

	// Control register layout
	localparam int          CTRL_W            = 8;
	localparam int          CTRL_UNLOCK_BIT   = 0;
	localparam int          CTRL_SELECT_BIT   = 1;
	localparam logic [7:0]  CTRL_RESET_VALUE  = 8'h00;

	// Unlock window length, in system clock cycles
	localparam int          UNLOCK_CYCLES     = 4;
	localparam int          UNLOCK_CNT_W      = 3;
	localparam logic [2:0]  UNLOCK_LOAD       = 3'(UNLOCK_CYCLES);
	localparam logic [2:0]  UNLOCK_ONE        = 3'h1;

	// Program memory word addressing
	localparam int          ADDR_W            = 14;
	localparam logic [13:0] FLASH_START       = 14'h0000;
	localparam logic [13:0] BOOT_START_4K     = 14'h3800;
	localparam logic [13:0] VECTOR_STRIDE     = 14'h0002;

	// Vector numbering: 1 is reset, 2 is the first external interrupt
	localparam int          VEC_NUM_W         = 5;
	localparam logic [4:0]  VEC_RESET_NUM     = 5'h01;
	localparam logic [4:0]  VEC_LAST_NUM      = 5'h15;

	// Fuse and lock levels: zero means programmed
	localparam logic        FUSE_PROGRAMMED   = 1'b0;
	localparam int          BOOT_SIZE_W       = 2;

	// Static configuration from fuses and lock bits
	typedef struct packed {
		logic                    boot_reset_fuse;
		logic [BOOT_SIZE_W-1:0]  boot_size_fuses;
		logic                    app_side_boot_lock;
		logic                    boot_side_boot_lock;
	} fuse_cfg_s;

	localparam int          FUSE_CFG_W        = $bits(fuse_cfg_s);
	localparam logic [4:0]  FUSE_CFG_RESET    = 5'h1F;

	// CPU write strobe with its data
	typedef struct packed {
		logic               wr;
		logic [CTRL_W-1:0]  data;
	} ctrl_write_s;

endpackage

// ### level_sync.sv
/*
  Two flip-flop synchroniser for a bundle of quasi-static levels.
  Assumes the bits change rarely enough that skew between bits of the
  bundle does not matter to the reader.
*/
`timescale 1ns/100ps

module level_sync #(
	parameter int          WIDTH     = 1,
	parameter logic [31:0] RESET_VAL = 32'h00000000
) (
	input  wire logic             i_mclk,   // System clock
	input  wire logic             i_reset,  // Synchronous reset, high
	input  wire logic [WIDTH-1:0] i_async,  // Levels from outside
	output logic      [WIDTH-1:0] o_sync    // Synchronised levels
);

	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			meta_ff <= RESET_VAL[WIDTH-1:0];
			o_sync  <= RESET_VAL[WIDTH-1:0];
		end
		else
		begin
			meta_ff <= i_async;
			o_sync  <= meta_ff;
		end
	end

endmodule

// ### vector_placement_monitor.sv
/*
  Checker for the vector placement block, bound to its top ports.
  Assumes fuse levels stay put while an unlock window runs.
*/
`timescale 1ns/100ps

module vector_placement_monitor
	import vector_placement_pkg::*;
(
	input wire logic                 i_mclk,         // Clock
	input wire logic                 i_reset,        // Sync reset
	input wire ctrl_write_s          i_ctrl_write,   // Write strobe
	input wire logic                 i_instr_done,   // Retire pulse
	input wire logic                 i_exec_in_boot, // Boot execution
	input wire fuse_cfg_s            i_fuses,        // Fuse levels
	input wire logic [VEC_NUM_W-1:0] i_vector_num,   // Lookup number
	input wire logic [CTRL_W-1:0]    o_ctrl_rdata,   // Register value
	input wire logic                 o_irq_block,    // Block level
	input wire logic [ADDR_W-1:0]    o_vector_addr,  // Vector address
	input wire logic [ADDR_W-1:0]    o_reset_addr    // Reset address
);
	// Write decode; free means neither lock can block
	wire unl = i_ctrl_write.wr & i_ctrl_write.data[CTRL_UNLOCK_BIT];
	wire sw = i_ctrl_write.wr & ~i_ctrl_write.data[CTRL_UNLOCK_BIT];
	wire act = o_ctrl_rdata[CTRL_UNLOCK_BIT];
	wire sel = o_ctrl_rdata[CTRL_SELECT_BIT];
	wire free = i_fuses.app_side_boot_lock & i_fuses.boot_side_boot_lock;
	wire app = i_fuses.app_side_boot_lock;
	wire bsl = i_fuses.boot_side_boot_lock;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	chk_unlock_opens: assert property (unl |=> act && o_irq_block)
		else $error("unlock write did not open window");
	chk_unlock_expires: assert property (unl ##1 !i_ctrl_write.wr [*4] |=> !act && (!o_irq_block || !free))
		else $error("unlock window length wrong");
	chk_select_taken: assert property (act && sw |=> sel == $past(i_ctrl_write.data[CTRL_SELECT_BIT])
		&& !act && o_irq_block)
		else $error("select write mishandled");
	chk_select_guard: assert property (unl || (sw && !act) |=> $stable(sel))
		else $error("select changed without unlock");
	chk_reserved_zero: assert property (o_ctrl_rdata[7:2] == 6'h00)
		else $error("reserved bits not zero");
	chk_hold_release: assert property (o_irq_block && !act && i_instr_done && !i_ctrl_write.wr
		&& free && $past(free) && $past(free, 2) |=> !o_irq_block)
		else $error("block not released after instruction");
	chk_flash_table: assert property (!i_ctrl_write.wr && !sel && i_vector_num inside {[2:21]}
		|=> o_vector_addr == {8'h00, $past(i_vector_num), 1'b0} - 14'h0002)
		else $error("flash vector address wrong");
	chk_app_lock: assert property (sel && !i_exec_in_boot && !app && !$past(app)
		&& !$past(app, 2) |=> o_irq_block)
		else $error("application lock did not block");
	chk_boot_lock: assert property (!sel && i_exec_in_boot && !bsl && !$past(bsl)
		&& !$past(bsl, 2) |=> o_irq_block)
		else $error("boot lock did not block");
endmodule

bind interrupt_vector_placement vector_placement_monitor u_monitor (
	.i_mclk(i_mclk), .i_reset(i_reset), .i_ctrl_write(i_ctrl_write), .i_instr_done(i_instr_done),
	.i_exec_in_boot(i_exec_in_boot), .i_fuses(i_fuses), .i_vector_num(i_vector_num),
	.o_ctrl_rdata(o_ctrl_rdata), .o_irq_block(o_irq_block), .o_vector_addr(o_vector_addr),
	.o_reset_addr(o_reset_addr));

// ### cpu_core_model.sv
/*
  CPU core stand-in: register writes, retire pulses, boot execution.
  Assumes its tasks are called at falling clock edges.
*/
`timescale 1ns/100ps

module cpu_core_model
	import vector_placement_pkg::*;
(
	input  wire logic   i_mclk,         // System clock
	output ctrl_write_s o_ctrl_write,   // Register write
	output logic        o_instr_done,   // Retire pulse
	output logic        o_exec_in_boot  // Running boot code
);
	// Idle core in application code
	initial
	begin
		o_ctrl_write = '0;
		o_instr_done = 1'b0;
		o_exec_in_boot = 1'b0;
	end

	// One write; keep holds the strobe so a second write can follow
	task put_write(input logic [7:0] d, input logic keep);
		o_ctrl_write = {1'b1, d}; // strobe high with data d, an unlock or a select write
		@(negedge i_mclk);
		if (!keep)
			o_ctrl_write.wr = 1'b0;
	endtask

	// One retired instruction
	task retire;
		o_instr_done = 1'b1;
		@(negedge i_mclk);
		o_instr_done = 1'b0;
	endtask

	// Move execution between sections
	task set_boot(input logic b);
		o_exec_in_boot = b;
	endtask
endmodule

// ### test_interrupt_vector_placement.sv
/*
  Self-checking bench for the vector placement block.
  Assumes the core model drives the write side at falling edges.
*/
`timescale 1ns/100ps

module test_interrupt_vector_placement
	import vector_placement_pkg::*;
;
	logic        i_mclk, i_reset, i_instr_done, i_exec_in_boot, o_irq_block, cur;
	ctrl_write_s i_ctrl_write;
	fuse_cfg_s   i_fuses;
	logic [4:0]  i_vector_num;
	logic [7:0]  o_ctrl_rdata;
	logic [13:0] o_vector_addr, o_reset_addr;
	int          err_count = 0, tests_run = 0, cycles = 0;

	cpu_core_model u_core (.i_mclk(i_mclk), .o_ctrl_write(i_ctrl_write), .o_instr_done(i_instr_done),
		.o_exec_in_boot(i_exec_in_boot));
	interrupt_vector_placement DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_ctrl_write(i_ctrl_write),
		.i_instr_done(i_instr_done), .i_exec_in_boot(i_exec_in_boot), .i_fuses(i_fuses),
		.i_vector_num(i_vector_num), .o_ctrl_rdata(o_ctrl_rdata), .o_irq_block(o_irq_block),
		.o_vector_addr(o_vector_addr), .o_reset_addr(o_reset_addr));

	// 250 MHz clock
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	// Ceiling far above the fewer than two hundred cycles the run needs
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_count++;
			finish_test;
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Select written 0..3 idle cycles after unlock; 4 is one too late
	task t_window;
		for (int g = 0; g < 5; g++)
		begin
			u_core.put_write(8'h01, g == 0);
			tick(g);
			check(16'({o_ctrl_rdata, o_irq_block}), {13'h0, cur, {2{g < 4}}}); // window length
			u_core.put_write({6'h00, ~g[0], 1'b0}, 1'b0); // unlock bit zero
			if (g < 4)
				cur = ~g[0];
			check(16'(o_ctrl_rdata), {14'h0, cur, 1'b0}); // select taken or kept
			if (g < 4)
			begin
				tick(2);
				check(16'(o_irq_block), 16'h0001); // held until retire
				u_core.retire;
			end
			check(16'(o_irq_block), 16'h0000); // released
			for (int n = 2; n < 22; n++)
			begin
				i_vector_num = 5'(n);
				tick(1);
				check(16'(o_vector_addr), 16'((cur ? BOOT_START_4K : FLASH_START) + 14'(2 * n - 2))); // table
			end
		end
	endtask

	// Select writes without unlock, and reserved bits
	task t_refused;
		u_core.put_write(8'hFE, 1'b1);
		check(16'(o_ctrl_rdata), 16'h0000); // ignored
		u_core.put_write(8'hFF, 1'b0);
		check(16'(o_ctrl_rdata), 16'h0001); // only unlock sets
		tick(5);
	endtask

	// Reset start address follows the boot reset fuse
	task t_fuses;
		i_fuses.boot_reset_fuse = FUSE_PROGRAMMED;
		i_vector_num = 5'h02;
		tick(4);
		check(16'(o_reset_addr), 16'h3800); // boot reset
		check(16'(o_vector_addr), 16'h0002); // vectors stay low
		i_vector_num = 5'h01;
		tick(1);
		check(16'(o_vector_addr), 16'h3800); // reset entry
		i_vector_num = 5'h00;
		tick(1);
		check(16'(o_vector_addr), 16'h0028); // out of range gives last entry
		i_fuses.boot_reset_fuse = ~FUSE_PROGRAMMED;
		tick(4);
		check(16'(o_reset_addr), 16'h0000); // flash start
	endtask

	task set_sel(input logic v);
		u_core.put_write(8'h01, 1'b1);
		u_core.put_write({6'h00, v, 1'b0}, 1'b0);
		u_core.retire;
	endtask

	// Lock bits block the section away from the vectors
	task t_locks;
		set_sel(1'b1);
		i_fuses.app_side_boot_lock = FUSE_PROGRAMMED;
		tick(4);
		check(16'(o_irq_block), 16'h0001); // application code blocked
		u_core.set_boot(1'b1);
		tick(2);
		check(16'(o_irq_block), 16'h0000); // boot code free
		i_fuses.app_side_boot_lock = ~FUSE_PROGRAMMED;
		set_sel(1'b0);
		i_fuses.boot_side_boot_lock = FUSE_PROGRAMMED;
		tick(4);
		check(16'(o_irq_block), 16'h0001); // boot code blocked
		u_core.set_boot(1'b0);
		tick(2);
		check(16'(o_irq_block), 16'h0000); // application free
		i_fuses.boot_side_boot_lock = ~FUSE_PROGRAMMED;
	endtask

	// Main sequence, with a second reset in mid-window at the end
	initial
	begin
		i_reset = 1'b1;
		i_fuses = FUSE_CFG_RESET;
		i_vector_num = 5'h02;
		cur = 1'b0;
		tick(8);
		check(16'({o_ctrl_rdata, o_irq_block}), 16'h0000); // reset values
		i_reset = 1'b0;
		tick(4);
		t_window;
		t_refused;
		t_fuses;
		t_locks;
		u_core.put_write(8'h01, 1'b0);
		i_reset = 1'b1;
		tick(2);
		check(16'({o_ctrl_rdata, o_irq_block}), 16'h0000); // reset values
		i_reset = 1'b0;
		tick(1);
		check(16'({o_ctrl_rdata, o_irq_block}), 16'h0000); // quiet after release
		finish_test;
	end
endmodule
